// ---- adc_defines.svh ----
// Constants for the serial converter control block
`ifndef ADC_DEFINES_SVH
`define ADC_DEFINES_SVH

// Clock rates and internal oscillator divider
`define SYS_CLK_HZ     125000000
`define OSC_NOM_HZ     4400000
`define OSC_DIV_CYC    (`SYS_CLK_HZ / `OSC_NOM_HZ)
`define OSC_CNT_W      5

// Clock mode codes held in the setup register
`define MODE_PIN_SEQ   2'b00
`define MODE_PIN_ONE   2'b01
`define MODE_SER_INT   2'b10
`define MODE_SER_EXT   2'b11
`define MODE_RESET     2'b10

// Command byte fields
`define CMD_CONV_BIT   7
`define CMD_SETUP_BIT  6
`define CMD_AVG_BIT    5
`define CMD_RST_BIT    4
`define CONV_CH_HI     6
`define CONV_CH_LO     3
`define CONV_SCAN_HI   2
`define CONV_SCAN_LO   1
`define CONV_TEMP_BIT  0
`define SETUP_CKM_HI   5
`define SETUP_CKM_LO   4
`define SETUP_REF_HI   3
`define SETUP_REF_LO   2
`define SETUP_DIFF_HI  1
`define SETUP_DIFF_LO  0
`define AVG_NSCAN_HI   1
`define AVG_NSCAN_LO   0
`define RST_FIFO_BIT   3

// Field codes
`define DIFF_UNI       2'b10
`define DIFF_BIP       2'b11
`define REF_NEG_CODE   2'b11
`define SCAN_UP_TO     2'b00
`define SCAN_FROM      2'b01
`define SCAN_REPEAT    2'b10
`define SCAN_ONCE      2'b11
`define SECOND_NONE    2'b00
`define SECOND_UNI     2'b01
`define SECOND_BIP     2'b10

// Channels, buffer and result layout
`define CONVERT_START_N_CH       4'hF
`define REFN_CH        4'hE
`define FIRST_CH       4'h0
`define LAST_CH        4'hF
`define FIFO_DEPTH     16
`define FIFO_FULL      5'h10
`define RES_PAD        4'h0
`define SYNC_RST       4'hC

`endif

// ---- adc_pkg.sv ----
// Types shared by the converter control block
package adc_pkg;
	`include "adc_defines.svh"

	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_PICK = 3'b001,
		S_WAIT = 3'b010
	} seq_state_t;

	typedef struct packed {
		logic [9:0] value;
		logic [1:0] sub;
		logic       negative;
	} sample_t;

	typedef struct packed {
		logic       temp;
		logic [3:0] channel;
		logic       differential;
		logic       bipolar;
	} conv_sel_t;

	typedef struct packed {
		seq_state_t                   state;
		logic [1:0]                   mode;
		logic [1:0]                   refsel;
		logic [7:0]                   uni;
		logic [7:0]                   bip;
		logic [1:0]                   nscan;
		logic [1:0]                   second;
		logic [3:0]                   conv_ch;
		logic [1:0]                   conv_scan;
		logic                         conv_temp;
		logic [3:0]                   ch;
		logic [3:0]                   last;
		logic [4:0]                   rep;
		logic [4:0]                   rep_init;
		logic                         temp_pend;
		conv_sel_t                    sel;
		logic                         start;
		logic [`FIFO_DEPTH-1:0][11:0] fifo;
		logic [3:0]                   wr;
		logic [3:0]                   rd;
		logic [4:0]                   count;
		logic [15:0]                  temp_word;
		logic                         temp_valid;
		logic                         half;
		logic [7:0]                   tx_byte;
		logic                         eoc_n;
		logic [`OSC_CNT_W-1:0]        osc_cnt;
		logic                         tick;
		logic [7:0]                   wait_cnt;
		logic                         rx_seen;
		logic                         take_seen;
		logic                         cs_prev;
		logic                         cnv_prev;
	} ctrl_state_t;
endpackage

// ---- bit_sync.sv ----
// Two-stage synchroniser, one chain per bit
`timescale 1ns/1ns
module bit_sync #(
	parameter int         W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         clk_in,
	input  wire logic         nrst_in,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);
	// Each bit passes two flip-flops; only the second is read
	for (genvar i = 0; i < W; i++) begin : g_bit
		logic meta_q;
		logic sync_q;
		always_ff @(posedge clk_in or negedge nrst_in) begin
			if (!nrst_in) begin
				meta_q <= RST_VAL[i];
				sync_q <= RST_VAL[i];
			end else begin
				meta_q <= d_in[i];
				sync_q <= meta_q;
			end
		end
		assign q_out[i] = sync_q;
	end
endmodule

// ---- serial_link.sv ----
// Serial-clock side of the 3-wire port: byte shifter in and out
`timescale 1ns/1ns
module serial_link (
	input  wire logic       sclk_in,
	input  wire logic       cs_n_in,
	input  wire logic       nrst_in,
	input  wire logic       din_in,
	input  wire logic [7:0] tx_byte_in,
	output logic            dout_out,
	output logic [7:0]      rx_byte_out,
	output logic            rx_tog_out,
	output logic            take_tog_out
);
	logic [2:0] bit_cnt_q;
	logic [6:0] shift_q;
	logic [7:0] shadow_q;
	logic       out_bit_q;
	logic       started_q;
	logic       load;

	// Input bits captured on rising edges while selected
	always_ff @(posedge sclk_in or posedge cs_n_in) begin
		if (cs_n_in) begin
			bit_cnt_q <= 3'h0;
			shift_q   <= 7'h00;
		end else begin
			bit_cnt_q <= bit_cnt_q + 3'h1;
			shift_q   <= {shift_q[5:0], din_in};
		end
	end

	// Completed byte and its toggle survive chip select changes
	always_ff @(posedge sclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rx_byte_out <= 8'h00;
			rx_tog_out  <= 1'b0;
		end else if (!cs_n_in && bit_cnt_q == 3'h7) begin
			rx_byte_out <= {shift_q, din_in};
			rx_tog_out  <= ~rx_tog_out;
		end
	end

	// Output byte is taken at the first falling edge of each byte
	assign load = !started_q || bit_cnt_q == 3'h0;

	always_ff @(negedge sclk_in or posedge cs_n_in) begin
		if (cs_n_in) begin
			shadow_q  <= 8'h00;
			out_bit_q <= 1'b0;
			started_q <= 1'b0;
		end else begin
			started_q <= 1'b1;
			if (load) begin
				shadow_q  <= tx_byte_in;
				out_bit_q <= tx_byte_in[3'h7 - bit_cnt_q];
			end else begin
				out_bit_q <= shadow_q[3'h7 - bit_cnt_q];
			end
		end
	end

	// Tells the system side that a byte left for the wire
	always_ff @(negedge sclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			take_tog_out <= 1'b0;
		end else if (!cs_n_in && load) begin
			take_tog_out <= ~take_tog_out;
		end
	end

	// Before the first falling edge the top bit of the oldest byte shows
	assign dout_out = started_q ? out_bit_q : tx_byte_in[7];
endmodule

// ---- adc_serial_control_fifo.sv ----
// Control side of a multichannel converter: serial port, clock modes, end flag, result buffer
//
// Overview of operation
// - Port works with clock idling low or high
// - Sample input on rising, change output on falling
// - Bipolar and temperature two's complement, else binary
// - Chip select fall opens; command byte first, MSB
// - Setup selecting polarity register takes next byte
// - Setup bits 5:4 pick clock mode, reset 10
// - Mode 00: start pin runs whole sequence
// - Mode 01: each start request converts one channel
// - Mode 10: conversion register write starts conversions
// - Mode 11: serial clock timed, no scan, no averaging
// - End flag low after sequence, per conversion in 01
// - End flag rises on select or start fall
// - Differential pairs are even positive, odd negative
// - Shared pins serve one role; reference removes channel
// - Pair bit one makes that pair differential
// - Unipolar negative clips zero; single-ended always unipolar
// - Buffer holds sixteen results plus one temperature
// - Full buffer drops oldest; empty reads zeros
// - Two bytes per result, oldest byte first
// - Temperature read first; newer replaces unread older
// - Internal oscillator runs in modes 00, 01, 10
// - Leading command bits select the target register
// - Channels used as pin roles are skipped
`timescale 1ns/1ns
`include "adc_defines.svh"
module adc_serial_control_fifo #(
	parameter int CONV_TICKS = 16
) (
	input  wire logic              sys_clk_in,
	input  wire logic              nrst_in,
	input  wire logic              sclk_in,
	input  wire logic              cs_n_in,
	input  wire logic              din_in,
	output logic                   dout_out,
	output logic                   dout_oe_out,
	input  wire logic              convert_start_n_in,
	output logic                   eoc_n_out,
	output logic                   conv_start_out,
	output adc_pkg::conv_sel_t     conv_sel_out,
	input  wire adc_pkg::sample_t  conv_in,
	output logic                   clock_mode_hi_out,
	output logic                   clock_mode_lo_out,
	output logic                   osc_run_out,
	output logic                   convert_start_n_pin_out,
	output logic                   ref_neg_out,
	output logic [4:0]             fifo_count_out,
	output logic                   temp_ready_out
);
	import adc_pkg::*;

	ctrl_state_t q;
	ctrl_state_t d;
	logic [7:0]  rx_byte;
	logic        rx_tog;
	logic        take_tog;
	logic [3:0]  sync_q;
	logic        cs_s;
	logic        cnv_s;
	logic        rx_ev;
	logic        take_ev;
	logic        cs_fall;
	logic        cnv_fall;
	logic        conv_done;
	logic [9:0]  coded;
	logic [1:0]  coded_sub;
	logic [15:0] word;

	// Power-on contents of every control flop
	function automatic ctrl_state_t reset_state();
		ctrl_state_t s;
		s          = '0;
		s.state    = S_IDLE;
		s.mode     = `MODE_RESET;
		s.eoc_n    = 1'b1;
		s.cs_prev  = 1'b1;
		s.cnv_prev = 1'b1;
		s.rep_init = 5'h01;
		return s;
	endfunction

	localparam ctrl_state_t RST_STATE = reset_state();

	// Channel given over to the start pin or the negative reference
	function automatic logic excluded(input ctrl_state_t s, input logic [3:0] c);
		return (c == `CONVERT_START_N_CH && !s.mode[1]) || (c == `REFN_CH && s.refsel == `REF_NEG_CODE);
	endfunction

	// Pair index p maps to bit 7-p of the polarity registers
	function automatic logic pair_diff(input ctrl_state_t s, input logic [3:0] c);
		logic [2:0] idx;
		idx = 3'h7 - c[3:1];
		return s.uni[idx] | s.bip[idx];
	endfunction

	// A channel converts only if free and not the odd half of a pair
	function automatic logic chan_ok(input ctrl_state_t s, input logic [3:0] c);
		logic diff;
		diff = pair_diff(s, c);
		return !excluded(s, c) && !(diff && (c[0] || excluded(s, {c[3:1], 1'b1})));
	endfunction

	// Loads the channel range of a new sequence from the conversion register
	function automatic ctrl_state_t begin_scan(input ctrl_state_t s, input logic single);
		ctrl_state_t r;
		logic [1:0]  scan;
		r         = s;
		scan      = (single || s.mode == `MODE_SER_EXT) ? `SCAN_ONCE : s.conv_scan;
		r.ch      = s.conv_ch;
		r.last    = s.conv_ch;
		r.rep_init = 5'h01;
		unique case (scan)
			`SCAN_UP_TO: begin
				r.ch = `FIRST_CH;
			end
			`SCAN_FROM: begin
				r.last = `LAST_CH;
			end
			`SCAN_REPEAT: begin
				r.rep_init = {3'(s.nscan) + 3'h1, 2'b00};
			end
			`SCAN_ONCE: begin
				r.rep_init = 5'h01;
			end
		endcase
		r.rep       = r.rep_init;
		r.temp_pend = s.conv_temp;
		r.state     = S_PICK;
		return r;
	endfunction

	// Pin and toggle inputs cross into the system clock
	bit_sync #(
		.W       (4),
		.RST_VAL (`SYNC_RST)
	) u_sync (
		.clk_in  (sys_clk_in),
		.nrst_in (nrst_in),
		.d_in    ({cs_n_in, convert_start_n_in, rx_tog, take_tog}),
		.q_out   (sync_q)
	);

	// Serial-clock domain shifter
	serial_link u_link (
		.sclk_in      (sclk_in),
		.cs_n_in      (cs_n_in),
		.nrst_in      (nrst_in),
		.din_in       (din_in),
		.tx_byte_in   (q.tx_byte),
		.dout_out     (dout_out),
		.rx_byte_out  (rx_byte),
		.rx_tog_out   (rx_tog),
		.take_tog_out (take_tog)
	);

	// Edge events seen in the system domain
	assign cs_s     = sync_q[3];
	assign cnv_s    = sync_q[2];
	assign rx_ev    = sync_q[1] != q.rx_seen;
	assign take_ev  = sync_q[0] != q.take_seen;
	assign cs_fall  = q.cs_prev && !cs_s;
	assign cnv_fall = q.cnv_prev && !cnv_s;

	// Conversion finishes on oscillator ticks, or on a byte of serial clock in mode 11
	assign conv_done = q.state == S_WAIT &&
		(q.mode == `MODE_SER_EXT ? rx_ev : (q.tick && q.wait_cnt == 8'(CONV_TICKS - 1)));

	// Output coding of the front-end sample
	always_comb begin
		coded     = conv_in.value;
		coded_sub = conv_in.sub;
		if (q.sel.temp || q.sel.bipolar) begin
			coded[9] = ~conv_in.value[9];
		end else if (q.sel.differential && conv_in.negative) begin
			coded     = 10'h000;
			coded_sub = 2'b00;
		end
	end

	// Next state of the whole control block
	always_comb begin
		d           = q;
		d.start     = 1'b0;
		d.rx_seen   = sync_q[1];
		d.take_seen = sync_q[0];
		d.cs_prev   = cs_s;
		d.cnv_prev  = cnv_s;
		d.tick      = 1'b0;

		// Internal oscillator, idle when the serial clock times conversions
		if (q.mode != `MODE_SER_EXT) begin
			if (q.osc_cnt == `OSC_CNT_W'(`OSC_DIV_CYC - 1)) begin
				d.osc_cnt = '0;
				d.tick    = 1'b1;
			end else begin
				d.osc_cnt = q.osc_cnt + 1'b1;
			end
		end else begin
			d.osc_cnt = '0;
		end

		// End flag rises on select or start fall
		if (cs_fall || cnv_fall) begin
			d.eoc_n = 1'b1;
		end

		// Pending polarity byte is dropped when the transfer ends
		if (cs_s) begin
			d.second = `SECOND_NONE;
		end

		// Byte readout: advance after each byte leaves for the wire
		if (take_ev) begin
			if (q.half) begin
				d.half = 1'b0;
				if (q.temp_valid) begin
					d.temp_valid = 1'b0;
				end else if (q.count != 5'h00) begin
					d.rd    = q.rd + 4'h1;
					d.count = q.count - 5'h01;
				end
			end else if (q.temp_valid || q.count != 5'h00) begin
				d.half = 1'b1;
			end
		end

		// Command decode on each completed byte
		if (rx_ev) begin
			if (q.second != `SECOND_NONE) begin
				if (q.second == `SECOND_UNI) begin
					d.uni = rx_byte;
				end else begin
					d.bip = rx_byte;
				end
				d.second = `SECOND_NONE;
			end else if (rx_byte[`CMD_CONV_BIT]) begin
				d.conv_ch   = rx_byte[`CONV_CH_HI:`CONV_CH_LO];
				d.conv_scan = rx_byte[`CONV_SCAN_HI:`CONV_SCAN_LO];
				d.conv_temp = rx_byte[`CONV_TEMP_BIT];
				if (q.mode[1] && q.state == S_IDLE) begin
					d = begin_scan(d, 1'b0);
				end
			end else if (rx_byte[`CMD_SETUP_BIT]) begin
				d.mode   = rx_byte[`SETUP_CKM_HI:`SETUP_CKM_LO];
				d.refsel = rx_byte[`SETUP_REF_HI:`SETUP_REF_LO];
				if (rx_byte[`SETUP_DIFF_HI:`SETUP_DIFF_LO] == `DIFF_UNI) begin
					d.second = `SECOND_UNI;
				end else if (rx_byte[`SETUP_DIFF_HI:`SETUP_DIFF_LO] == `DIFF_BIP) begin
					d.second = `SECOND_BIP;
				end
			end else if (rx_byte[`CMD_AVG_BIT]) begin
				d.nscan = rx_byte[`AVG_NSCAN_HI:`AVG_NSCAN_LO];
			end else if (rx_byte[`CMD_RST_BIT]) begin
				if (!rx_byte[`RST_FIFO_BIT]) begin
					d           = RST_STATE;
					d.rx_seen   = sync_q[1];
					d.take_seen = sync_q[0];
					d.cs_prev   = cs_s;
					d.cnv_prev  = cnv_s;
				end
				d.wr         = 4'h0;
				d.rd         = 4'h0;
				d.count      = 5'h00;
				d.temp_valid = 1'b0;
				d.half       = 1'b0;
			end
		end

		// Start pin requests in the pin-driven modes
		if (cnv_fall && q.state == S_IDLE && !q.mode[1]) begin
			if (q.mode == `MODE_PIN_SEQ) begin
				d = begin_scan(d, 1'b0);
			end else begin
				d = begin_scan(d, 1'b1);
			end
		end

		// Sequencer
		unique case (q.state)
			S_IDLE: begin
			end
			S_PICK: begin
				d.wait_cnt = 8'h00;
				if (q.temp_pend) begin
					d.temp_pend = 1'b0;
					d.sel       = '{temp: 1'b1, channel: 4'h0, differential: 1'b0, bipolar: 1'b0};
					d.start     = 1'b1;
					d.state     = S_WAIT;
				end else if (chan_ok(q, q.ch)) begin
					d.sel.temp         = 1'b0;
					d.sel.channel      = q.ch;
					d.sel.differential = pair_diff(q, q.ch);
					d.sel.bipolar      = q.bip[3'h7 - q.ch[3:1]] && pair_diff(q, q.ch);
					d.start            = 1'b1;
					d.state            = S_WAIT;
				end else if (q.ch == q.last) begin
					d.state = S_IDLE;
					d.eoc_n = q.mode == `MODE_SER_EXT;
				end else begin
					d.ch = q.ch + 4'h1;
				end
			end
			S_WAIT: begin
				if (q.tick) begin
					d.wait_cnt = q.wait_cnt + 8'h01;
				end
				if (conv_done) begin
					if (q.sel.temp) begin
						d.temp_word  = {`RES_PAD, coded, coded_sub};
						d.temp_valid = 1'b1;
						d.state      = S_PICK;
					end else begin
						d.fifo[q.wr] = {coded, coded_sub};
						d.wr         = q.wr + 4'h1;
						if (d.count == `FIFO_FULL) begin
							d.rd = d.rd + 4'h1;
						end else begin
							d.count = d.count + 5'h01;
						end
						if (q.rep > 5'h01) begin
							d.rep   = q.rep - 5'h01;
							d.state = S_PICK;
						end else if (q.ch == q.last) begin
							d.state = S_IDLE;
							d.eoc_n = q.mode == `MODE_SER_EXT;
						end else begin
							d.ch    = q.ch + 4'h1;
							d.rep   = q.rep_init;
							d.state = S_PICK;
						end
					end
				end
			end
			default: begin
				d.state = S_IDLE;
			end
		endcase

		// End flag never falls in the serial-timed mode
		if (d.mode == `MODE_SER_EXT) begin
			d.eoc_n = 1'b1;
		end

		// Oldest unread byte waits at the shifter; zeros when empty
		if (d.temp_valid) begin
			word = d.temp_word;
		end else if (d.count != 5'h00) begin
			word = {`RES_PAD, d.fifo[d.rd]};
		end else begin
			word = 16'h0000;
		end
		d.tx_byte = d.half ? word[7:0] : word[15:8];
	end

	// Control state register
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			q <= RST_STATE;
		end else begin
			q <= d;
		end
	end

	// Status and front-end outputs
	assign dout_oe_out       = !cs_n_in;
	assign eoc_n_out         = q.eoc_n;
	assign conv_start_out    = q.start;
	assign conv_sel_out      = q.sel;
	assign clock_mode_hi_out = q.mode[1];
	assign clock_mode_lo_out = q.mode[0];
	assign osc_run_out       = q.mode != `MODE_SER_EXT;
	assign convert_start_n_pin_out     = !q.mode[1];
	assign ref_neg_out       = q.refsel == `REF_NEG_CODE;
	assign fifo_count_out    = q.count;
	assign temp_ready_out    = q.temp_valid;
endmodule

// ---- adc_ctrl_properties.sv ----
// Concurrent checks on the converter control block ports
`timescale 1ns/1ns
module adc_ctrl_properties
	import adc_pkg::*;
(
	input wire logic               sys_clk_in,
	input wire logic               nrst_in,
	input wire logic               sclk_in,
	input wire logic               cs_n_in,
	input wire logic               din_in,
	input wire logic               dout_out,
	input wire logic               dout_oe_out,
	input wire logic               convert_start_n_in,
	input wire logic               eoc_n_out,
	input wire logic               conv_start_out,
	input wire adc_pkg::conv_sel_t conv_sel_out,
	input wire adc_pkg::sample_t   conv_in,
	input wire logic               clock_mode_hi_out,
	input wire logic               clock_mode_lo_out,
	input wire logic               osc_run_out,
	input wire logic               convert_start_n_pin_out,
	input wire logic               ref_neg_out,
	input wire logic [4:0]         fifo_count_out,
	input wire logic               temp_ready_out
);
	// All checks run on the system clock
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!nrst_in);

	mode_reset_a: assert property ($rose(nrst_in) |-> clock_mode_hi_out && !clock_mode_lo_out)
		else $error("clock mode not 10 after reset");
	osc_mode_a: assert property (osc_run_out == !(clock_mode_hi_out && clock_mode_lo_out))
		else $error("oscillator state wrong for clock mode");
	eoc_mode11_a: assert property (clock_mode_hi_out && clock_mode_lo_out |-> eoc_n_out)
		else $error("end flag low in external clock mode");
	eoc_cs_a: assert property ($fell(cs_n_in) |-> ##[1:5] eoc_n_out)
		else $error("end flag not raised by select fall");
	eoc_pin_a: assert property ($fell(convert_start_n_in) && convert_start_n_pin_out |-> ##[1:5] eoc_n_out)
		else $error("end flag not raised by start pin fall");
	pin_role_a: assert property (convert_start_n_pin_out == !clock_mode_hi_out)
		else $error("start pin role does not follow clock mode");
	skip_pin_a: assert property (conv_start_out && convert_start_n_pin_out && !conv_sel_out.temp |-> conv_sel_out.channel != 4'hF)
		else $error("conversion started on start pin channel");
	skip_ref_a: assert property (conv_start_out && ref_neg_out && !conv_sel_out.temp |-> conv_sel_out.channel != 4'hE)
		else $error("conversion started on reference channel");
	pair_even_a: assert property (conv_start_out && conv_sel_out.differential |-> !conv_sel_out.channel[0])
		else $error("differential pair not on even channel");
	single_uni_a: assert property (conv_start_out && !conv_sel_out.differential |-> !conv_sel_out.bipolar)
		else $error("single-ended conversion marked bipolar");
	fifo_cap_a: assert property (fifo_count_out <= 5'h10)
		else $error("result count above sixteen");

	// Main scenarios reached
	cover property (conv_start_out && conv_sel_out.differential);
	cover property ($fell(eoc_n_out) && convert_start_n_pin_out);
	cover property (fifo_count_out == 5'h10);
endmodule

bind adc_serial_control_fifo adc_ctrl_properties u_adc_ctrl_properties (
	.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .sclk_in(sclk_in), .cs_n_in(cs_n_in),
	.din_in(din_in), .dout_out(dout_out), .dout_oe_out(dout_oe_out),
	.convert_start_n_in(convert_start_n_in), .eoc_n_out(eoc_n_out), .conv_start_out(conv_start_out),
	.conv_sel_out(conv_sel_out), .conv_in(conv_in), .clock_mode_hi_out(clock_mode_hi_out),
	.clock_mode_lo_out(clock_mode_lo_out), .osc_run_out(osc_run_out), .convert_start_n_pin_out(convert_start_n_pin_out),
	.ref_neg_out(ref_neg_out), .fifo_count_out(fifo_count_out), .temp_ready_out(temp_ready_out)
);

// ---- host_serial_model.sv ----
// Host serial master model for the 3-wire port
`timescale 1ns/1ns
module host_serial_model (
	input  wire logic cpol_in,
	input  wire logic miso_in,
	output logic      sclk_out,
	output logic      cs_n_out,
	output logic      mosi_out
);
	// Idle bus: deselected, clock still
	initial begin
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		mosi_out = 1'b0;
	end

	// Rest the clock at the chosen polarity, then select
	task automatic open_frame();
		sclk_out = cpol_in;
		#6 cs_n_out = 1'b0;
		#6;
	endtask

	// Deselect; the released data line no longer shows its last level
	task automatic close_frame();
		#6 cs_n_out = 1'b1;
		mosi_out = ~mosi_out;
		#12;
	endtask

	// One byte, MSB first: drive after the falling edge, sample at the rising edge
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			sclk_out = 1'b0;
			mosi_out = tx[i];
			#6 sclk_out = 1'b1;
			rx[i] = miso_in;
			#6;
		end
		if (!cpol_in) sclk_out = 1'b0;
	endtask
endmodule

// ---- adc_serial_control_fifo_tb.sv ----
// Self-checking bench for the converter control block
`timescale 1ns/1ns
module adc_serial_control_fifo_tb;
	import adc_pkg::*;
	logic        sys_clk, rst_n, cnv_n, dout, dout_oe, eoc_n, cstart, hi, lo, osc, pin, refn, tready;
	logic        sclk, cs_n, din, cpol;
	conv_sel_t   sel;
	sample_t     smp, smp_v;
	logic [4:0]  cnt;
	logic [15:0] fq[$], tq[$], got_w, w, e_w;
	event        got_e;
	int          n_fail, compares, seed;

	adc_serial_control_fifo #(.CONV_TICKS(2)) u_adc_serial_control_fifo (
		.sys_clk_in(sys_clk), .nrst_in(rst_n), .sclk_in(sclk), .cs_n_in(cs_n), .din_in(din),
		.dout_out(dout), .dout_oe_out(dout_oe), .convert_start_n_in(cnv_n), .eoc_n_out(eoc_n),
		.conv_start_out(cstart), .conv_sel_out(sel), .conv_in(smp), .clock_mode_hi_out(hi),
		.clock_mode_lo_out(lo), .osc_run_out(osc), .convert_start_n_pin_out(pin), .ref_neg_out(refn),
		.fifo_count_out(cnt), .temp_ready_out(tready));
	host_serial_model u_host_serial_model (.cpol_in(cpol), .miso_in(dout), .sclk_out(sclk),
		.cs_n_out(cs_n), .mosi_out(din));

	// System clock, 8 ns
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
		compares++;
		if (s !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// Command frame of one or two bytes
	task automatic wr(input logic [7:0] a, input logic [7:0] b, input logic two);
		logic [7:0] r;
		u_host_serial_model.open_frame();
		u_host_serial_model.xfer(a, r);
		if (two) u_host_serial_model.xfer(b, r);
		u_host_serial_model.close_frame();
		repeat (6) @(posedge sys_clk);
		#1;
	endtask

	// Read n result words; the monitor judges each
	task automatic rd(input int n);
		logic [7:0] h, l;
		u_host_serial_model.open_frame();
		chk("dout enable", 16'h1, {15'h0, dout_oe});
		repeat (n) begin
			u_host_serial_model.xfer(8'h00, h);
			u_host_serial_model.xfer(8'h00, l);
			got_w = {h, l};
			-> got_e;
		end
		u_host_serial_model.close_frame();
		repeat (6) @(posedge sys_clk);
		#1;
	endtask

	task automatic wait_eoc(input logic [4:0] n);
		int k;
		k = 0;
		while (eoc_n !== 1'b0 && k < 5000) begin
			@(posedge sys_clk);
			k++;
		end
		#1;
		chk("end flag", 16'h0, {15'h0, eoc_n});
		chk("result count", {11'h0, n}, {11'h0, cnt});
	endtask

	task automatic pulse();
		@(posedge sys_clk) cnv_n <= 1'b0;
		repeat (4) @(posedge sys_clk);
		cnv_n <= 1'b1;
	endtask

	// Front end: answer each start with a random sample and note the word due back
	always @(posedge sys_clk) begin
		if (cstart === 1'b1) begin
			smp_v = sample_t'(13'($random(seed)));
			smp_v.negative = smp_v.negative & sel.differential;
			smp <= smp_v;
			w = {4'h0, smp_v.value ^ {sel.temp | sel.bipolar, 9'h0}, smp_v.sub};
			if (sel.differential && !sel.bipolar && smp_v.negative) w = 16'h0;
			if (sel.temp) tq = {w};
			else fq.push_back(w);
			if (fq.size() > 16) void'(fq.pop_front());
		end
	end

	// Compare each word read against the oldest note
	always @(got_e) begin
		if (tq.size() > 0) e_w = tq.pop_front();
		else if (fq.size() > 0) e_w = fq.pop_front();
		else e_w = 16'h0;
		chk("read word", e_w, got_w);
	end

	initial begin
		#400000;
		n_fail++;
		conclude();
	end

	initial begin
		seed = 32'h05EB;
		n_fail = 0;
		compares = 0;
		cpol = 1'b0;
		rst_n = 1'b0;
		cnv_n = 1'b1;
		smp = '0;
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		#1;
		chk("mode", 16'h2, {14'h0, hi, lo});
		chk("oscillator", 16'h1, {15'h0, osc});
		chk("dout enable", 16'h0, {15'h0, dout_oe});
		rd(1);
		$display("test reset done");
		cpol = 1'b1;
		wr(8'h70, 8'h00, 1'b0);
		chk("mode", 16'h3, {14'h0, hi, lo});
		chk("oscillator", 16'h0, {15'h0, osc});
		wr(8'h60, 8'h00, 1'b0);
		chk("mode", 16'h2, {14'h0, hi, lo});
		cpol = 1'b0;
		$display("test clock polarity done");
		wr(8'h91, 8'h00, 1'b0);
		wait_eoc(5'h3);
		chk("temp ready", 16'h1, {15'h0, tready});
		rd(4);
		$display("test scan with temperature done");
		wr(8'h63, 8'h80, 1'b1);
		wr(8'h62, 8'h40, 1'b1);
		wr(8'h98, 8'h00, 1'b0);
		wait_eoc(5'h2);
		rd(2);
		wr(8'h10, 8'h00, 1'b0);
		chk("count", 16'h0, {11'h0, cnt});
		$display("test differential done");
		wr(8'hF8, 8'h00, 1'b0);
		wait_eoc(5'h10);
		wr(8'hB6, 8'h00, 1'b0);
		wait_eoc(5'h10);
		rd(17);
		$display("test overflow done");
		wr(8'hE2, 8'h00, 1'b0);
		wait_eoc(5'h4);
		rd(4);
		wr(8'h4C, 8'h00, 1'b0);
		chk("pin roles", 16'h3, {14'h0, pin, refn});
		pulse();
		wait_eoc(5'h2);
		rd(2);
		$display("test pin sequence done");
		wr(8'h5C, 8'h00, 1'b0);
		pulse();
		wait_eoc(5'h1);
		pulse();
		wait_eoc(5'h2);
		rd(2);
		$display("test single request done");
		conclude();
	end
endmodule
